// [hw/rcr_pkg.sv]
package rcr_pkg;
    // register byte addresses on the serial port
    localparam logic [7:0] ADDR_ENABLE   = 8'h0b;
    localparam logic [7:0] ADDR_REG12    = 8'h0c;
    localparam logic [7:0] ADDR_REG4     = 8'h0e;
    localparam logic [7:0] ADDR_REG5     = 8'h0f;
    localparam logic [7:0] ADDR_REG3     = 8'h16;
    localparam logic [7:0] ADDR_SHARED   = 8'hb7;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // power-up values
    localparam logic [7:0] RST_ENABLE = 8'hfd;
    localparam logic [7:0] RST_REG12  = 8'hcf;
    localparam logic [7:0] RST_REG3   = 8'h81;
    localparam logic [7:0] RST_REG4   = 8'hbc;
    localparam logic [7:0] RST_REG5   = 8'hbe;
    localparam logic [7:0] RST_SHARED = 8'h00;

    // field positions
    localparam int EN_REG1_BIT     = 7;
    localparam int EN_REG5_BIT     = 3;
    localparam int EN_CARD_LVL_BIT = 2;
    localparam int EN_CARD_ON_BIT  = 1;
    localparam int EN_BACKUP_BIT   = 0;
    localparam int DRAIN_HI_BIT    = 7;
    localparam int DRAIN_LO_BIT    = 3;
    localparam int CODE3_HI        = 6;
    localparam int CODE3_LO        = 4;
    localparam int CODE3B_HI       = 2;
    localparam int CODE7_HI        = 6;
    localparam int SH_FIXED_BIT    = 5;
    localparam int SH_BACKUP_LVL   = 3;

    // serial port
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [6:0] DEV_ADDR_DEF  = 7'h48; // arbitrary value

    typedef enum logic [3:0] {
        RCR_IDLE, RCR_ADDR, RCR_ADDR_ACK, RCR_PTR, RCR_PTR_ACK,
        RCR_WDATA, RCR_WDATA_ACK, RCR_RDATA, RCR_RACK
    } rcr_state_e;
endpackage

// [hw/rcr_reg_cell.sv]
`timescale 1ns/1ps
module rcr_reg_cell
    import rcr_pkg::*;
#(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input  wire logic       i_mclk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_wr_en,
    input  wire logic [7:0] i_wr_data,
    output logic      [7:0] o_q
);
    typedef struct packed {
        logic [7:0] q;
    } rcr_cell_s;

    rcr_cell_s cell_reg;
    rcr_cell_s cell_next;

    always_comb begin
        cell_next = cell_reg;
        if (i_wr_en) begin
            cell_next.q = i_wr_data;
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cell_reg.q <= RESET_VAL;
        end else begin
            cell_reg <= cell_next;
        end
    end

    assign o_q = cell_reg.q;
endmodule // rcr_reg_cell

// [hw/rcr_regulator_ctrl.sv]
`timescale 1ns/1ps
// Function
// - each register sits at a fixed byte address, third regulator at 0x16, shared at 0xb7.
// - all bits of the enable and setting registers are writable and read back as last written.
// - power-up reset loads every field with its default so regulators 1 to 5 start on at defaults, the fixed regulator off.
// - enable bit 2 selects the card supply level, zero for 3.0 V and one for 1.80 V.
// - setting register 1/2 holds per regulator a drain enable (bit 7 or 3) and a 3-bit code.
// - settings 3 to 5: drain enable in bit 7, 7-bit code below; regulator 3 defaults to 1.25 V.
// - a regulator switched off with its drain enable set has its output pulled to ground.
module rcr_regulator_ctrl
    import rcr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
    input  wire logic       i_mclk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda,
    output logic            o_sda_oe,
    output logic      [4:0] o_regulator_on,
    output logic      [4:0] o_drain_on,
    output logic      [2:0] o_regulator1_code,
    output logic      [2:0] o_regulator2_code,
    output logic      [6:0] o_regulator3_code,
    output logic      [6:0] o_regulator4_code,
    output logic      [6:0] o_regulator5_code,
    output logic            o_card_supply_on,
    output logic            o_card_supply_level_select,
    output logic            o_backup_supply_on,
    output logic            o_backup_level_select,
    output logic            o_fixed_regulator_on,
    output logic      [7:0] o_shared_pin_ctrl
);
    typedef struct packed {
        rcr_state_e state;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic       rw;
        logic       scl_q;
        logic       sda_q;
        logic       sda_oe;
        logic       wr_pulse;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
        logic [4:0] drain;
    } rcr_ctrl_s;

    rcr_ctrl_s  ctl_reg;
    rcr_ctrl_s  ctl_next;
    logic [7:0] rd_mux;
    logic [7:0] regulator_enable_ctrl;
    logic [7:0] regulator12_setting;
    logic [7:0] regulator3_setting;
    logic [7:0] regulator4_setting;
    logic [7:0] regulator5_setting;
    logic [7:0] shared_pin_regulator_ctrl;
    logic [4:0] disch_en;
    logic       start_c;
    logic       stop_c;
    logic       rise_c;
    logic       fall_c;

    // register cells, each strobed by a decoded write
    rcr_reg_cell #(.RESET_VAL(RST_ENABLE)) u_en (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_wr_en(ctl_reg.wr_pulse && ctl_reg.wr_addr == ADDR_ENABLE),
        .i_wr_data(ctl_reg.wr_data), .o_q(regulator_enable_ctrl));
    rcr_reg_cell #(.RESET_VAL(RST_REG12)) u_r12 (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_wr_en(ctl_reg.wr_pulse && ctl_reg.wr_addr == ADDR_REG12),
        .i_wr_data(ctl_reg.wr_data), .o_q(regulator12_setting));
    rcr_reg_cell #(.RESET_VAL(RST_REG3)) u_r3 (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_wr_en(ctl_reg.wr_pulse && ctl_reg.wr_addr == ADDR_REG3),
        .i_wr_data(ctl_reg.wr_data), .o_q(regulator3_setting));
    rcr_reg_cell #(.RESET_VAL(RST_REG4)) u_r4 (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_wr_en(ctl_reg.wr_pulse && ctl_reg.wr_addr == ADDR_REG4),
        .i_wr_data(ctl_reg.wr_data), .o_q(regulator4_setting));
    rcr_reg_cell #(.RESET_VAL(RST_REG5)) u_r5 (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_wr_en(ctl_reg.wr_pulse && ctl_reg.wr_addr == ADDR_REG5),
        .i_wr_data(ctl_reg.wr_data), .o_q(regulator5_setting));
    rcr_reg_cell #(.RESET_VAL(RST_SHARED)) u_sh (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_wr_en(ctl_reg.wr_pulse && ctl_reg.wr_addr == ADDR_SHARED),
        .i_wr_data(ctl_reg.wr_data), .o_q(shared_pin_regulator_ctrl));

    always_comb begin
        case (ctl_reg.ptr)
            ADDR_ENABLE: rd_mux = regulator_enable_ctrl;
            ADDR_REG12:  rd_mux = regulator12_setting;
            ADDR_REG3:   rd_mux = regulator3_setting;
            ADDR_REG4:   rd_mux = regulator4_setting;
            ADDR_REG5:   rd_mux = regulator5_setting;
            ADDR_SHARED: rd_mux = shared_pin_regulator_ctrl;
            default:     rd_mux = UNMAPPED_READ;
        endcase
    end

    assign disch_en = {regulator12_setting[DRAIN_HI_BIT], regulator12_setting[DRAIN_LO_BIT],
                       regulator3_setting[DRAIN_HI_BIT], regulator4_setting[DRAIN_HI_BIT],
                       regulator5_setting[DRAIN_HI_BIT]};
    assign start_c = i_scl && ctl_reg.scl_q && ctl_reg.sda_q && !i_sda;
    assign stop_c  = i_scl && ctl_reg.scl_q && !ctl_reg.sda_q && i_sda;
    assign rise_c  = i_scl && !ctl_reg.scl_q;
    assign fall_c  = !i_scl && ctl_reg.scl_q;

    always_comb begin
        ctl_next          = ctl_reg;
        ctl_next.scl_q    = i_scl;
        ctl_next.sda_q    = i_sda;
        ctl_next.wr_pulse = 1'b0;
        // bit 4 is regulator 1, bit 0 regulator 5, drained only while off
        ctl_next.drain    = ~regulator_enable_ctrl[EN_REG1_BIT:EN_REG5_BIT] & disch_en;
        if (start_c) begin
            ctl_next.state  = RCR_ADDR;
            ctl_next.cnt    = 4'h0;
            ctl_next.sda_oe = 1'b0;
        end else if (stop_c) begin
            ctl_next.state  = RCR_IDLE;
            ctl_next.sda_oe = 1'b0;
        end else begin
            case (ctl_reg.state)
                RCR_ADDR, RCR_PTR, RCR_WDATA: begin
                    if (rise_c) begin
                        ctl_next.shreg = {ctl_reg.shreg[6:0], i_sda};
                        ctl_next.cnt   = ctl_reg.cnt + 4'h1;
                    end else if (fall_c && ctl_reg.cnt == BITS_PER_BYTE) begin
                        ctl_next.sda_oe = 1'b1;
                        ctl_next.cnt    = 4'h0;
                        if (ctl_reg.state == RCR_ADDR) begin
                            if (ctl_reg.shreg[7:1] == DEV_ADDR) begin
                                ctl_next.rw    = ctl_reg.shreg[0];
                                ctl_next.state = RCR_ADDR_ACK;
                            end else begin
                                ctl_next.sda_oe = 1'b0;
                                ctl_next.state  = RCR_IDLE;
                            end
                        end else if (ctl_reg.state == RCR_PTR) begin
                            ctl_next.ptr   = ctl_reg.shreg;
                            ctl_next.state = RCR_PTR_ACK;
                        end else begin
                            ctl_next.wr_pulse = 1'b1;
                            ctl_next.wr_addr  = ctl_reg.ptr;
                            ctl_next.wr_data  = ctl_reg.shreg;
                            ctl_next.state    = RCR_WDATA_ACK;
                        end
                    end
                end
                RCR_ADDR_ACK, RCR_PTR_ACK, RCR_WDATA_ACK: begin
                    if (fall_c) begin
                        ctl_next.sda_oe = 1'b0;
                        if (ctl_reg.state == RCR_ADDR_ACK && ctl_reg.rw) begin
                            ctl_next.shreg  = rd_mux;
                            ctl_next.sda_oe = ~rd_mux[7];
                            ctl_next.state  = RCR_RDATA;
                        end else if (ctl_reg.state == RCR_ADDR_ACK) begin
                            ctl_next.state = RCR_PTR;
                        end else begin
                            ctl_next.state = RCR_WDATA;
                        end
                    end
                end
                RCR_RDATA: begin
                    if (rise_c) begin
                        ctl_next.cnt = ctl_reg.cnt + 4'h1;
                    end else if (fall_c && ctl_reg.cnt == BITS_PER_BYTE) begin
                        ctl_next.sda_oe = 1'b0;
                        ctl_next.state  = RCR_RACK;
                    end else if (fall_c) begin
                        ctl_next.shreg  = {ctl_reg.shreg[6:0], 1'b0};
                        ctl_next.sda_oe = ~ctl_reg.shreg[6];
                    end
                end
                RCR_RACK: begin
                    if (rise_c && i_sda) begin
                        ctl_next.state = RCR_IDLE;
                    end else if (fall_c) begin
                        ctl_next.shreg  = rd_mux;
                        ctl_next.sda_oe = ~rd_mux[7];
                        ctl_next.cnt    = 4'h0;
                        ctl_next.state  = RCR_RDATA;
                    end
                end
                default: begin
                    ctl_next.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctl_reg       <= '0;
            ctl_reg.state <= RCR_IDLE;
            ctl_reg.scl_q <= 1'b1;
            ctl_reg.sda_q <= 1'b1;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    assign o_sda                      = 1'b0;
    assign o_sda_oe                   = ctl_reg.sda_oe;
    assign o_drain_on                 = ctl_reg.drain;
    assign o_regulator_on             = regulator_enable_ctrl[EN_REG1_BIT:EN_REG5_BIT];
    assign o_card_supply_level_select = regulator_enable_ctrl[EN_CARD_LVL_BIT];
    assign o_card_supply_on           = regulator_enable_ctrl[EN_CARD_ON_BIT];
    assign o_backup_supply_on         = regulator_enable_ctrl[EN_BACKUP_BIT];
    assign o_regulator1_code          = regulator12_setting[CODE3_HI:CODE3_LO];
    assign o_regulator2_code          = regulator12_setting[CODE3B_HI:0];
    assign o_regulator3_code          = regulator3_setting[CODE7_HI:0];
    assign o_regulator4_code          = regulator4_setting[CODE7_HI:0];
    assign o_regulator5_code          = regulator5_setting[CODE7_HI:0];
    assign o_fixed_regulator_on       = shared_pin_regulator_ctrl[SH_FIXED_BIT];
    assign o_backup_level_select      = shared_pin_regulator_ctrl[SH_BACKUP_LVL];
    assign o_shared_pin_ctrl          = shared_pin_regulator_ctrl;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    chk_third_reg_addr: assert property (
        ctl_reg.wr_pulse && ctl_reg.wr_addr == ADDR_REG3
        |=> o_regulator3_code == $past(ctl_reg.wr_data[6:0]))
        else $error("third regulator write missed");
    chk_read_back: assert property (
        ctl_reg.state == RCR_ADDR_ACK && fall_c && ctl_reg.rw && !start_c && !stop_c
        |=> ctl_reg.shreg == $past(rd_mux) && o_sda_oe == ~$past(rd_mux[7]))
        else $error("read data not loaded");
    chk_power_defaults: assert property (
        $past(i_sys_rst) |-> o_regulator_on == 5'h1f && o_regulator3_code == 7'h01
        && !o_fixed_regulator_on && o_regulator1_code == 3'h4)
        else $error("power-up defaults wrong");
    chk_card_level: assert property (
        ctl_reg.wr_pulse && ctl_reg.wr_addr == ADDR_ENABLE
        |=> o_card_supply_level_select == $past(ctl_reg.wr_data[2]))
        else $error("card level not updated");
    chk_pair_fields: assert property (
        ctl_reg.wr_pulse && ctl_reg.wr_addr == ADDR_REG12
        |=> o_regulator1_code == $past(ctl_reg.wr_data[6:4])
        && o_regulator2_code == $past(ctl_reg.wr_data[2:0]))
        else $error("pair setting fields wrong");
    chk_reg4_code: assert property (
        ctl_reg.wr_pulse && ctl_reg.wr_addr == ADDR_REG4
        |=> o_regulator4_code == $past(ctl_reg.wr_data[6:0]))
        else $error("regulator 4 code wrong");
    chk_fixed_enable: assert property (
        ctl_reg.wr_pulse && ctl_reg.wr_addr == ADDR_SHARED
        |=> o_fixed_regulator_on == $past(ctl_reg.wr_data[5]))
        else $error("fixed regulator enable wrong");
    chk_drain_switch: assert property (
        !o_regulator_on[4] && disch_en[4] |=> o_drain_on[4])
        else $error("off regulator not drained");

    cov_write: cover property (ctl_reg.wr_pulse && ctl_reg.wr_addr == ADDR_REG3);
    cov_read: cover property (ctl_reg.state == RCR_RACK && fall_c);
    cov_drain: cover property (o_drain_on != 5'h00);
endmodule // rcr_regulator_ctrl

// [test/rcr_host_model.sv]
`timescale 1ns/1ps
module rcr_host_model
    import rcr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
    input  wire logic i_mclk,
    input  wire logic i_sda_line,
    output logic      o_scl,
    output logic      o_sda
);
    // o_sda high means released; the line is pulled up
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    task automatic start_cond();
        o_sda = 1'b1;
        tick(4);
        o_scl = 1'b1;
        tick(4);
        o_sda = 1'b0;
        tick(4);
        o_scl = 1'b0;
        tick(1);
    endtask
    task automatic stop_cond();
        o_sda = 1'b0;
        tick(4);
        o_scl = 1'b1;
        tick(4);
        o_sda = 1'b1;
        tick(8);
    endtask
    // data only moves while the clock is low
    task automatic bit_cycle(input logic b, output logic seen);
        o_sda = b;
        tick(4);
        o_scl = 1'b1;
        tick(2);
        seen = i_sda_line;
        tick(2);
        o_scl = 1'b0;
        tick(1);
    endtask
    task automatic send_byte(input logic [7:0] d, output logic nak);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(d[i], s);
        end
        bit_cycle(1'b1, nak);
    endtask
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            d[i] = s;
        end
        bit_cycle(last, s);
    endtask
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d0,
                             input logic [7:0] d1, input bit two, output logic nak);
        logic n1;
        logic n2;
        start_cond();
        send_byte({dev, 1'b0}, nak);
        if (nak === 1'b0) begin
            send_byte(a, n1);
            send_byte(d0, n2);
            nak = n1 | n2;
            if (two) begin
                send_byte(d1, n2);
                nak = nak | n2;
            end
        end
        stop_cond();
    endtask
    // two bytes in one read, the first acknowledged by the host
    task automatic read_pair(input logic [7:0] a, output logic [15:0] d);
        logic n;
        start_cond();
        send_byte({DEV_ADDR, 1'b0}, n);
        send_byte(a, n);
        start_cond();
        send_byte({DEV_ADDR, 1'b1}, n);
        recv_byte(1'b0, d[15:8]);
        recv_byte(1'b1, d[7:0]);
        stop_cond();
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic nak);
        logic n1;
        logic n2;
        start_cond();
        send_byte({DEV_ADDR, 1'b0}, nak);
        send_byte(a, n1);
        start_cond();
        send_byte({DEV_ADDR, 1'b1}, n2);
        recv_byte(1'b1, d);
        stop_cond();
        nak = nak | n1 | n2;
    endtask
endmodule // rcr_host_model

// [test/tb_regulator_control_registers.sv]
`timescale 1ns/1ps
module tb_regulator_control_registers;
    import rcr_pkg::*;
    typedef struct packed { logic [7:0] addr; logic [7:0] data; logic [7:0] exp; } rcr_row_s;
    logic i_mclk, i_sys_rst, o_sda, o_sda_oe, scl, msda, sda_line, nak;
    logic o_card_supply_on, o_card_supply_level_select, o_backup_supply_on;
    logic o_backup_level_select, o_fixed_regulator_on;
    logic [4:0] o_regulator_on, o_drain_on;
    logic [2:0] o_regulator1_code, o_regulator2_code;
    logic [6:0] o_regulator3_code, o_regulator4_code, o_regulator5_code;
    logic [7:0] o_shared_pin_ctrl, rd, img [0:255];
    logic [15:0] rd2;
    rcr_row_s rows [12];
    int err_count = 0, checked = 0, cycles = 0;
    assign sda_line = msda & ~(o_sda_oe & ~o_sda);
    rcr_regulator_ctrl dut_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_scl(scl),
        .i_sda(sda_line), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_regulator_on(o_regulator_on),
        .o_drain_on(o_drain_on), .o_regulator1_code(o_regulator1_code),
        .o_regulator2_code(o_regulator2_code), .o_regulator3_code(o_regulator3_code),
        .o_regulator4_code(o_regulator4_code), .o_regulator5_code(o_regulator5_code),
        .o_card_supply_on(o_card_supply_on),
        .o_card_supply_level_select(o_card_supply_level_select),
        .o_backup_supply_on(o_backup_supply_on), .o_backup_level_select(o_backup_level_select),
        .o_fixed_regulator_on(o_fixed_regulator_on), .o_shared_pin_ctrl(o_shared_pin_ctrl));
    rcr_host_model mdl_u (.i_mclk(i_mclk), .i_sda_line(sda_line), .o_scl(scl), .o_sda(msda));
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            close_out();
        end
    end
    task automatic init_img();
        img[8'h0b] = RST_ENABLE;
        img[8'h0c] = RST_REG12;
        img[8'h16] = RST_REG3;
        img[8'h0e] = RST_REG4;
        img[8'h0f] = RST_REG5;
        img[8'hb7] = RST_SHARED;
    endtask
    task automatic check_outs();
        logic [7:0] en, r12, r3, r4, r5, sh;
        en = img[8'h0b];
        r12 = img[8'h0c];
        r3 = img[8'h16];
        r4 = img[8'h0e];
        r5 = img[8'h0f];
        sh = img[8'hb7];
        chk("reg_on", {3'h0, o_regulator_on}, {3'h0, en[7:3]});
        chk("drain", {3'h0, o_drain_on},
            {3'h0, ~en[7:3] & {r12[7], r12[3], r3[7], r4[7], r5[7]}});
        chk("code1", {5'h0, o_regulator1_code}, {5'h0, r12[6:4]});
        chk("code2", {5'h0, o_regulator2_code}, {5'h0, r12[2:0]});
        chk("code3", {1'b0, o_regulator3_code}, {1'b0, r3[6:0]});
        chk("code4", {1'b0, o_regulator4_code}, {1'b0, r4[6:0]});
        chk("code5", {1'b0, o_regulator5_code}, {1'b0, r5[6:0]});
        chk("card", {6'h0, o_card_supply_on, o_card_supply_level_select},
            {6'h0, en[1], en[2]});
        chk("backup", {6'h0, o_backup_supply_on, o_backup_level_select},
            {6'h0, en[0], sh[3]});
        chk("fixed", {7'h0, o_fixed_regulator_on}, {7'h0, sh[5]});
        chk("shared", o_shared_pin_ctrl, sh);
    endtask
    task automatic check_regs();
        logic [7:0] a [6];
        a = '{8'h0b, 8'h0c, 8'h16, 8'h0e, 8'h0f, 8'hb7};
        foreach (a[k]) begin
            mdl_u.read_reg(a[k], rd, nak);
            chk("reset_read", rd, img[a[k]]);
        end
    endtask
    task automatic do_reset();
        i_sys_rst = 1'b1;
        init_img();
        repeat (6) @(negedge i_mclk);
        i_sys_rst = 1'b0;
        repeat (2) @(negedge i_mclk);
        check_outs();
        check_regs();
    endtask
    initial begin
        rows = '{'{8'h0b, 8'h00, 8'h00}, '{8'h0c, 8'h4a, 8'h4a}, '{8'h16, 8'h05, 8'h05},
                 '{8'h0e, 8'h7f, 8'h7f}, '{8'h0f, 8'h80, 8'h80}, '{8'hb7, 8'h28, 8'h28},
                 '{8'h20, 8'h55, 8'h00}, '{8'h0b, 8'ha6, 8'ha6}, '{8'h0c, 8'hb7, 8'hb7},
                 '{8'h16, 8'hff, 8'hff}, '{8'hb7, 8'hd7, 8'hd7}, '{8'h0b, 8'h03, 8'h03}};
        do_reset();
        foreach (rows[k]) begin
            mdl_u.write_reg(DEV_ADDR_DEF, rows[k].addr, rows[k].data, 8'h00, 1'b0, nak);
            chk("ack", {7'h0, nak}, 8'h00);
            if (rows[k].addr inside {8'h0b, 8'h0c, 8'h0e, 8'h0f, 8'h16, 8'hb7}) begin
                img[rows[k].addr] = rows[k].data;
            end
            mdl_u.read_reg(rows[k].addr, rd, nak);
            chk("readback", rd, rows[k].exp);
            check_outs();
        end
        // foreign device address must be ignored
        mdl_u.write_reg(DEV_ADDR_DEF ^ 7'h01, 8'h0b, 8'hf8, 8'h00, 1'b0, nak);
        chk("foreign_nak", {7'h0, nak}, 8'h01);
        check_outs();
        // two data bytes rewrite the same register, neighbour untouched
        mdl_u.write_reg(DEV_ADDR_DEF, 8'h0e, 8'h11, 8'h22, 1'b1, nak);
        img[8'h0e] = 8'h22;
        mdl_u.read_reg(8'h0f, rd, nak);
        chk("neighbour", rd, img[8'h0f]);
        mdl_u.read_reg(8'h0e, rd, nak);
        chk("rewrite", rd, 8'h22);
        check_outs();
        // a two-byte read returns the same register twice
        mdl_u.read_pair(8'h0e, rd2);
        chk("pair_first", rd2[15:8], img[8'h0e]);
        chk("pair_second", rd2[7:0], img[8'h0e]);
        do_reset();
        close_out();
    end
endmodule // tb_regulator_control_registers
